// File: hw/slic_edge.sv
// Synchroniser and edge detector for one request pin
`timescale 1ns/10ps
`default_nettype none
module slic_edge (
  input wire logic clk,
  input wire logic rst,
  input wire logic pin,
  input wire logic rise_en,
  input wire logic fall_en,
  output logic edge_pulse
);
  logic sync1_reg;
  logic sync2_reg;
  logic last_reg;
  logic [1:0] warm_reg;

  // Edges ignored until the stages hold real pin samples
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      warm_reg <= 2'h0;
    end else if (warm_reg != 2'h3) begin
      warm_reg <= warm_reg + 2'h1;
    end
  end

  // Two flip-flops ahead of any logic, then one more for the edge
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      last_reg <= 1'b0;
    end else begin
      sync1_reg <= pin;
      sync2_reg <= sync1_reg;
      last_reg <= sync2_reg;
    end
  end

  // One pulse per detected edge
  always_comb begin
    edge_pulse = (warm_reg == 2'h3) &
                 ((rise_en & sync2_reg & ~last_reg) | (fall_en & ~sync2_reg & last_reg));
  end

  rise_pulse_a: assert property (@(posedge clk) disable iff (rst)
    (warm_reg == 2'h3 && rise_en && $rose(sync2_reg)) |-> edge_pulse)
    else $error("rising edge missed");
endmodule
`default_nettype wire

// File: hw/slic_prio.sv
// Programmable priority encoder for six request levels
`timescale 1ns/10ps
`default_nettype none
module slic_prio
  import slic_pkg::*;
(
  input wire logic [5:0] pend,
  input wire logic [7:0] prio,
  output logic found,
  output logic [2:0] level
);
  // Groups: A = levels 1,4; B = levels 0,2; C = levels 3,5
  logic [1:0] a_pair;
  logic [1:0] b_pair;
  logic [1:0] c_pair;
  logic [2:0] a_lvl;
  logic [2:0] b_lvl;
  logic [2:0] c_lvl;
  logic [2:0] ord;

  always_comb begin
    a_pair = prio[5] ? {pend[4], pend[1]} : {pend[1], pend[4]};
    a_lvl = prio[5] ? (pend[4] ? 3'h4 : 3'h1) : (pend[1] ? 3'h1 : 3'h4);
    b_pair = {pend[0], pend[2]};
    b_lvl = prio[2] ? (pend[2] ? 3'h2 : 3'h0) : (pend[0] ? 3'h0 : 3'h2);
    c_pair = {pend[3], pend[5]};
    c_lvl = prio[1] ? (pend[3] ? 3'h3 : 3'h5) : (pend[5] ? 3'h5 : 3'h3);
    ord = {prio[4], prio[3], prio[0]};
    found = |pend;
    level = 3'h0;
    // Groups ranked by order field values 1 to 6, then within-group bit; values 0 and 7 pick the lowest pending level
    unique case (ord)
      3'h1: level = |c_pair ? c_lvl : (|a_pair ? a_lvl : b_lvl);
      3'h2: level = |a_pair ? a_lvl : (|b_pair ? b_lvl : c_lvl);
      3'h3: level = |a_pair ? a_lvl : (|c_pair ? c_lvl : b_lvl);
      3'h4: level = |b_pair ? b_lvl : (|c_pair ? c_lvl : a_lvl);
      3'h5: level = |c_pair ? c_lvl : (|b_pair ? b_lvl : a_lvl);
      3'h6: level = |b_pair ? b_lvl : (|a_pair ? a_lvl : c_lvl);
      default: level = found ? (pend[0] ? 3'h0 : pend[1] ? 3'h1 : pend[2] ? 3'h2 :
                       pend[3] ? 3'h3 : pend[4] ? 3'h4 : 3'h5) : 3'h0;
    endcase
  end
endmodule
`default_nettype wire

// File: hw/slic_top.sv
// Six-level interrupt controller with register port and vector sequencer
//
// Local design decisions: the strobed register port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
module slic_top
  import slic_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic port5_line1,
  input wire logic port5_line2,
  input wire logic port5_line3,
  input wire logic comparator1,
  input wire logic comparator2,
  input wire logic sixteen_bit_timer,
  input wire logic eight_bit_timer,
  input wire logic prescaled_timer,
  input wire logic low_voltage_detector,
  input wire logic lvd_enable,
  input wire logic enable_interrupts_instruction,
  input wire logic disable_interrupts_instruction,
  input wire logic core_ack,
  input wire logic [7:0] prog_data,
  output logic vec_req,
  output logic [15:0] prog_addr,
  output logic prog_rd,
  output logic push_ctx,
  output logic [15:0] vec_addr,
  output logic vec_valid,
  output logic [2:0] vec_level
);
  import slic_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // Source conditioning
  logic p51_edge;
  logic p52_edge;
  logic p53_edge;
  logic [5:0] src_sync1_reg;
  logic [5:0] src_sync2_reg;
  logic [5:0] src_last_reg;
  logic [5:0] src_rise;
  logic [5:0] hw_set;

  slic_edge u_edge_p52 (
    .clk(clk),
    .rst(rst),
    .pin(port5_line2),
    .rise_en(1'b1),
    .fall_en(1'b1),
    .edge_pulse(p52_edge)
  );

  slic_edge u_edge_p53 (
    .clk(clk),
    .rst(rst),
    .pin(port5_line3),
    .rise_en(1'b0),
    .fall_en(1'b1),
    .edge_pulse(p53_edge)
  );

  slic_edge u_edge_p51 (
    .clk(clk),
    .rst(rst),
    .pin(port5_line1),
    .rise_en(1'b1),
    .fall_en(1'b1),
    .edge_pulse(p51_edge)
  );

  // Internal events: comp2, comp1, t16, t8, prescaled timer, low voltage
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      src_sync1_reg <= 6'h00;
      src_sync2_reg <= 6'h00;
      src_last_reg <= 6'h00;
    end else begin
      src_sync1_reg <= {low_voltage_detector, prescaled_timer, eight_bit_timer,
                        sixteen_bit_timer, comparator1, comparator2};
      src_sync2_reg <= src_sync1_reg;
      src_last_reg <= src_sync2_reg;
    end
  end

  logic lvd_en_sync1_reg;
  logic lvd_en_reg;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lvd_en_sync1_reg <= 1'b0;
      lvd_en_reg <= 1'b0;
    end else begin
      lvd_en_sync1_reg <= lvd_enable;
      lvd_en_reg <= lvd_en_sync1_reg;
    end
  end

  always_comb begin
    src_rise = src_sync2_reg & ~src_last_reg;
    hw_set = 6'h00;
    hw_set[LVL_P52] = p52_edge | src_rise[0];
    hw_set[LVL_P53] = p53_edge;
    hw_set[LVL_P51] = p51_edge | src_rise[1];
    hw_set[LVL_T16] = src_rise[2];
    hw_set[LVL_T8] = src_rise[3];
    // Low voltage owns level 5 while enabled
    hw_set[LVL_SHARED] = lvd_en_reg ? src_rise[5] : src_rise[4];
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [5:0] req_reg;
  logic [7:0] mask_reg;
  logic [7:0] prio_reg;
  logic armed_reg;
  logic gen_reg;
  logic wr_req;
  logic wr_mask;
  logic wr_prio;
  logic accept;
  logic [2:0] win_level;
  logic [5:0] accept_clr;

  always_comb begin
    wr_req = reg_wr && (reg_addr == ADDR_REQ);
    wr_mask = reg_wr && (reg_addr == ADDR_MASK);
    wr_prio = reg_wr && (reg_addr == ADDR_PRIO);
    accept_clr = accept ? (6'h01 << win_level) : 6'h00;
  end

  // Request bits: write sets by value, hardware set wins over clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      req_reg <= REQ_RESET[5:0];
    end else if (wr_req) begin
      req_reg <= (reg_wdata[5:0] & ~accept_clr) | hw_set;
    end else begin
      req_reg <= (req_reg & ~accept_clr) | hw_set;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mask_reg <= MASK_RESET;
    end else if (wr_mask) begin
      mask_reg <= reg_wdata;
    end else if (accept || disable_interrupts_instruction) begin
      mask_reg[MASK_GLOBAL_BIT] <= 1'b0;
    end else if (enable_interrupts_instruction) begin
      mask_reg[MASK_GLOBAL_BIT] <= 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prio_reg <= PRIO_RESET;
    end else if (wr_prio) begin
      prio_reg <= reg_wdata;
    end
  end

  // First enable instruction arms the mask bit path
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      armed_reg <= 1'b0;
    end else if (enable_interrupts_instruction) begin
      armed_reg <= 1'b1;
    end
  end

  always_comb begin
    gen_reg = armed_reg & mask_reg[MASK_GLOBAL_BIT];
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      unique case (reg_addr)
        ADDR_REQ: reg_rdata <= {2'h0, req_reg};
        ADDR_MASK: reg_rdata <= mask_reg;
        ADDR_PRIO: reg_rdata <= prio_reg;
        ADDR_STAT: reg_rdata <= {armed_reg, gen_reg, 6'h00};
        default: reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Arbitration
  logic [5:0] pend;
  logic found;

  always_comb begin
    pend = req_reg & mask_reg[5:0];
  end

  slic_prio u_prio (
    .pend(pend),
    .prio(prio_reg),
    .found(found),
    .level(win_level)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Vector sequencer
  slic_state_type state_reg;
  logic [2:0] lvl_reg;
  logic [7:0] hi_reg;

  always_comb begin
    accept = (state_reg == SLIC_IDLE) && gen_reg && found;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= SLIC_IDLE;
    end else begin
      unique case (state_reg)
        SLIC_IDLE: if (accept) state_reg <= SLIC_PUSH;
        SLIC_PUSH: if (core_ack) state_reg <= SLIC_FETCH_HI;
        SLIC_FETCH_HI: state_reg <= SLIC_FETCH_LO;
        SLIC_FETCH_LO: state_reg <= SLIC_JUMP;
        SLIC_JUMP: state_reg <= SLIC_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lvl_reg <= 3'h0;
      vec_level <= 3'h0;
    end else if (accept) begin
      lvl_reg <= win_level;
      vec_level <= win_level;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      vec_req <= 1'b0;
      push_ctx <= 1'b0;
    end else begin
      vec_req <= accept || (state_reg == SLIC_PUSH && !core_ack);
      push_ctx <= accept;
    end
  end

  // Even byte is upper half, odd is lower
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prog_addr <= 16'h0000;
      prog_rd <= 1'b0;
    end else if (state_reg == SLIC_PUSH && core_ack) begin
      prog_addr <= VEC_BASE + {12'h000, lvl_reg, 1'b0};
      prog_rd <= 1'b1;
    end else if (state_reg == SLIC_FETCH_HI) begin
      prog_addr <= VEC_BASE + {12'h000, lvl_reg, 1'b1};
      prog_rd <= 1'b1;
    end else begin
      prog_rd <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hi_reg <= 8'h00;
      vec_addr <= 16'h0000;
      vec_valid <= 1'b0;
    end else begin
      vec_valid <= (state_reg == SLIC_JUMP);
      if (state_reg == SLIC_FETCH_HI) begin
        hi_reg <= prog_data;
      end
      if (state_reg == SLIC_FETCH_LO) begin
        vec_addr <= {hi_reg, prog_data};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence accept_s;
    accept;
  endsequence

  no_arm_a: assert property (@(posedge clk) disable iff (rst)
    !armed_reg |-> !accept) else $error("vector taken before enable");
  mask_gate_a: assert property (@(posedge clk) disable iff (rst)
    accept |-> mask_reg[win_level]) else $error("masked level vectored");
  req_clear_a: assert property (@(posedge clk) disable iff (rst)
    accept_s ##1 !$past(hw_set[win_level]) |-> !req_reg[lvl_reg])
    else $error("request not cleared");
  gen_clear_a: assert property (@(posedge clk) disable iff (rst)
    accept && !wr_mask |=> !mask_reg[MASK_GLOBAL_BIT]) else $error("enable kept");
  push_pulse_a: assert property (@(posedge clk) disable iff (rst)
    accept |=> push_ctx ##1 !push_ctx) else $error("push missing");
  lvd_block_a: assert property (@(posedge clk) disable iff (rst)
    (lvd_en_reg && !src_rise[5] && !wr_req && !req_reg[LVL_SHARED])
    |=> !req_reg[LVL_SHARED]) else $error("timer leaked");
  sw_set_a: assert property (@(posedge clk) disable iff (rst)
    (wr_req && !accept) |=> ((req_reg & $past(reg_wdata[5:0])) == $past(reg_wdata[5:0])))
    else $error("software request lost");
  hw_keep_a: assert property (@(posedge clk) disable iff (rst)
    hw_set[LVL_P53] |=> req_reg[LVL_P53]) else $error("level 1 request lost");
  vec_order_a: assert property (@(posedge clk) disable iff (rst)
    (state_reg == SLIC_PUSH && core_ack) |=> !prog_addr[0] ##1 prog_addr[0])
    else $error("vector byte order");
endmodule
`default_nettype wire

// File: inc/slic_pkg.sv
// Package with constants and types for the six-level interrupt controller
package slic_pkg;
  localparam int LEVELS = 6;
  localparam logic [7:0] ADDR_REQ = 8'hfa;
  localparam logic [7:0] ADDR_MASK = 8'hfb;
  localparam logic [7:0] ADDR_PRIO = 8'hf9;
  localparam logic [7:0] ADDR_STAT = 8'hf8;
  localparam logic [7:0] REQ_RESET = 8'h00;
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [7:0] PRIO_RESET = 8'h00;
  localparam int MASK_GLOBAL_BIT = 7;
  localparam int LVL_P52 = 0;
  localparam int LVL_P53 = 1;
  localparam int LVL_P51 = 2;
  localparam int LVL_T16 = 3;
  localparam int LVL_T8 = 4;
  localparam int LVL_SHARED = 5;
  localparam logic [15:0] VEC_BASE = 16'h0000;
  localparam int FETCH_BYTES = 2;
  typedef enum logic [2:0] {
    SLIC_ORD_012,
    SLIC_ORD_120,
    SLIC_ORD_201,
    SLIC_ORD_210,
    SLIC_ORD_021,
    SLIC_ORD_102
  } slic_order_type;
  typedef enum {
    SLIC_IDLE,
    SLIC_PUSH,
    SLIC_FETCH_HI,
    SLIC_FETCH_LO,
    SLIC_JUMP
  } slic_state_type;
endpackage

// File: verif/slic_core_model.sv
// Behavioural model of the processor core that serves vector requests
`timescale 1ns/10ps
`default_nettype none
module slic_core_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic vec_req,
  input wire logic prog_rd,
  input wire logic [15:0] prog_addr,
  input wire logic [3:0] dly,
  output logic core_ack,
  output logic [7:0] prog_data
);
  logic [3:0] cnt_reg;
  logic done_reg;
  ////////////////////////////////////////////////////////////////////////////////
  // Acknowledge the context push after a chosen delay, once per request
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      core_ack <= 1'b0;
      cnt_reg <= 4'h0;
      done_reg <= 1'b0;
    end else begin
      core_ack <= 1'b0;
      if (!vec_req) begin
        cnt_reg <= 4'h0;
        done_reg <= 1'b0;
      end else if (!done_reg) begin
        if (cnt_reg == dly) begin
          core_ack <= 1'b1;
          done_reg <= 1'b1;
        end else begin
          cnt_reg <= cnt_reg + 4'h1;
        end
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Vector table: upper byte at even place, lower at odd; junk when not read
  assign prog_data = !prog_rd ? ~prog_addr[7:0] :
                     prog_addr[0] ? {4'h3, prog_addr[3:0]} : {4'hc, prog_addr[3:0]};
endmodule
`default_nettype wire

// File: verif/slic_top_tb.sv
// Self-checking testbench for the six-level interrupt controller
`timescale 1ns/10ps
`default_nettype none
module slic_top_tb;
  import slic_pkg::*;
  logic clk, rst, reg_wr, reg_rd, ei, di, core_ack, vec_req, prog_rd, push_ctx, vec_valid;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, prog_data;
  logic [9:0] src;
  logic [3:0] dly;
  logic [15:0] prog_addr, vec_addr;
  logic [2:0] vec_level;
  int miscompares, n_compared, cyc;
  slic_top dut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .port5_line1(src[0]),
    .port5_line2(src[1]), .port5_line3(src[2]), .comparator1(src[3]), .comparator2(src[4]),
    .sixteen_bit_timer(src[5]), .eight_bit_timer(src[6]), .prescaled_timer(src[7]),
    .low_voltage_detector(src[8]), .lvd_enable(src[9]), .enable_interrupts_instruction(ei),
    .disable_interrupts_instruction(di), .core_ack(core_ack), .prog_data(prog_data),
    .vec_req(vec_req), .prog_addr(prog_addr), .prog_rd(prog_rd), .push_ctx(push_ctx),
    .vec_addr(vec_addr), .vec_valid(vec_valid), .vec_level(vec_level));
  slic_core_model core (.clk(clk), .rst(rst), .vec_req(vec_req), .prog_rd(prog_rd),
    .prog_addr(prog_addr), .dly(dly), .core_ack(core_ack), .prog_data(prog_data));
  ////////////////////////////////////////////////////////////////////////////////
  // Clock, timeout and shared tasks
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      final_report();
    end
  end
  task automatic final_report();
    if (miscompares == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(logic [15:0] got, logic [15:0] exp, string what);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    chk({8'h00, reg_rdata}, {8'h00, e}, "register read");
  endtask
  task automatic instr(logic en);
    @(posedge clk);
    if (en) ei <= 1'b1;
    else di <= 1'b1;
    @(posedge clk);
    ei <= 1'b0;
    di <= 1'b0;
  endtask
  task automatic quiet(int n);
    repeat (n) begin
      @(negedge clk);
      chk({15'h0, vec_req}, 16'h0, "unexpected vector request");
    end
  endtask
  task automatic service(logic [2:0] lv);
    logic [7:0] b;
    int pushes;
    b = {4'h0, lv, 1'b0};
    pushes = 0;
    for (int i = 0; i < 60 && vec_valid !== 1'b1; i++) begin
      @(negedge clk);
      if (push_ctx === 1'b1) pushes++;
    end
    chk({15'h0, vec_valid}, 16'h1, "vector valid");
    chk(pushes[15:0], 16'h1, "context push");
    chk({13'h0, vec_level}, {13'h0, lv}, "vector level");
    chk(vec_addr, {8'hc0 + b, 8'h31 + b}, "vector address");
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset();
    rd(ADDR_REQ, REQ_RESET);
    rd(ADDR_MASK, MASK_RESET);
    rd(ADDR_PRIO, PRIO_RESET);
    rd(ADDR_STAT, 8'h00);
    rd(8'h10, 8'h00);
  endtask
  task automatic t_first_enable();
    wr(ADDR_MASK, 8'hff);
    wr(ADDR_REQ, 8'h01);
    rd(ADDR_REQ, 8'h01);
    rd(ADDR_STAT, 8'h00);
    quiet(20);
    instr(1'b1);
    service(3'd0);
    rd(ADDR_REQ, 8'h00);
    rd(ADDR_MASK, 8'h7f);
    rd(ADDR_STAT, 8'h80);
  endtask
  task automatic t_mask_prio();
    dly <= 4'h3;
    instr(1'b0);
    wr(ADDR_PRIO, 8'h19);
    wr(ADDR_MASK, 8'h08);
    wr(ADDR_REQ, 8'h32);
    instr(1'b1);
    quiet(20);
    rd(ADDR_STAT, 8'hc0);
    instr(1'b0);
    wr(ADDR_REQ, 8'h3a);
    wr(ADDR_MASK, 8'hb8);
    service(3'd3);
    instr(1'b1);
    service(3'd4);
    instr(1'b1);
    service(3'd5);
    rd(ADDR_REQ, 8'h02);
    instr(1'b0);
    wr(ADDR_PRIO, 8'h0c);
    wr(ADDR_REQ, 8'h0d);
    wr(ADDR_MASK, 8'h8d);
    service(3'd2);
    instr(1'b1);
    service(3'd0);
    instr(1'b1);
    service(3'd3);
    rd(ADDR_REQ, 8'h00);
    dly <= 4'h0;
  endtask
  task automatic t_sources();
    int idx[16] = '{1, 1, 2, 2, 0, 0, 3, 3, 4, 5, 6, 7, 7, 9, 7, 8};
    logic [7:0] exp[16] = '{8'h01, 8'h01, 8'h00, 8'h02, 8'h04, 8'h04, 8'h04, 8'h00,
                            8'h01, 8'h08, 8'h10, 8'h20, 8'h00, 8'h00, 8'h00, 8'h20};
    instr(1'b0);
    wr(ADDR_MASK, 8'h00);
    wr(ADDR_REQ, 8'h00);
    for (int i = 0; i < 16; i++) begin
      @(posedge clk);
      src[idx[i]] <= ~src[idx[i]];
      repeat (6) @(posedge clk);
      rd(ADDR_REQ, exp[i]);
      wr(ADDR_REQ, 8'h00);
      rd(ADDR_REQ, 8'h00);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    ei = 1'b0;
    di = 1'b0;
    src = 10'h000;
    dly = 4'h0;
    miscompares = 0;
    n_compared = 0;
    cyc = 0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_first_enable();
    t_mask_prio();
    t_sources();
    final_report();
  end
endmodule
`default_nettype wire
